// ---- tb/mwc_regs_test.sv ----
// Self-checking testbench for the wake, checksum and PHY control registers
`timescale 1ns/10ps
`default_nettype none
module mwc_regs_test;
	import mwc_pkg::*;
	localparam int SRST = 4;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_index = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic [31:0] reg_rdata;
	logic reg_rvalid;
	logic phy_wr = 1'b0;
	logic phy_rd = 1'b0;
	logic [4:0] phy_index = 5'h00;
	logic [15:0] phy_wdata = 16'h0;
	logic [15:0] phy_rdata;
	logic phy_rvalid;
	mwc_rx_evt_t rx_evt = '0;
	logic an_done = 1'b0;
	logic an_speed_100 = 1'b1;
	logic an_full_duplex = 1'b1;
	logic wake_frame_enable;
	logic magic_packet_wake_enable;
	logic wake_exit;
	mwc_coe_cfg_t coe_cfg;
	mwc_phy_ctl_t phy_ctl;
	logic phy_soft_reset;
	logic phy_an_restart;
	int fail_count = 0;
	int compares = 0;
	int n;

	// 25 MHz clock
	always #20 mclk = ~mclk;

	mwc_regs #(.SRST_CYC(SRST)) dut (.mclk(mclk), .reset(reset),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_index(reg_index),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .phy_wr(phy_wr), .phy_rd(phy_rd),
		.phy_index(phy_index), .phy_wdata(phy_wdata),
		.phy_rdata(phy_rdata), .phy_rvalid(phy_rvalid), .rx_evt(rx_evt),
		.an_done(an_done), .an_speed_100(an_speed_100),
		.an_full_duplex(an_full_duplex),
		.wake_frame_enable(wake_frame_enable),
		.magic_packet_wake_enable(magic_packet_wake_enable),
		.wake_exit(wake_exit), .coe_cfg(coe_cfg), .phy_ctl(phy_ctl),
		.phy_soft_reset(phy_soft_reset), .phy_an_restart(phy_an_restart));

	// Compare a register or bus value
	task automatic chk_word(input string name, input logic [31:0] exp,
		input logic [31:0] got);
	begin
		compares++;
		if (got !== exp)
		begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	end
	endtask : chk_word

	// Compare a single control level or pulse
	task automatic chk_bit(input string name, input logic exp,
		input logic got);
	begin
		compares++;
		if (got !== exp)
		begin
			fail_count++;
			$display("MISMATCH %s expected %b seen %b", name, exp, got);
		end
	end
	endtask : chk_bit

	// MAC register write, one-cycle strobe
	task automatic reg_write(input logic [7:0] idx, input logic [31:0] d);
	begin
		@(negedge mclk);
		reg_wr = 1'b1;
		reg_index = idx;
		reg_wdata = d;
		@(negedge mclk);
		reg_wr = 1'b0;
	end
	endtask : reg_write

	// MAC register read and compare
	task automatic reg_read(input logic [7:0] idx, input logic [31:0] exp);
	begin
		@(negedge mclk);
		reg_rd = 1'b1;
		reg_index = idx;
		@(negedge mclk);
		reg_rd = 1'b0;
		chk_bit("reg_rvalid", 1'b1, reg_rvalid);
		chk_word("reg_rdata", exp, reg_rdata);
	end
	endtask : reg_read

	// PHY register write by index
	task automatic phy_write(input logic [4:0] idx, input logic [15:0] d);
	begin
		@(negedge mclk);
		phy_wr = 1'b1;
		phy_index = idx;
		phy_wdata = d;
		@(negedge mclk);
		phy_wr = 1'b0;
	end
	endtask : phy_write

	// PHY register read by index and compare
	task automatic phy_read(input logic [4:0] idx, input logic [15:0] exp);
	begin
		@(negedge mclk);
		phy_rd = 1'b1;
		phy_index = idx;
		@(negedge mclk);
		phy_rd = 1'b0;
		chk_bit("phy_rvalid", 1'b1, phy_rvalid);
		chk_word("phy_rdata", {16'h0, exp}, {16'h0, phy_rdata});
	end
	endtask : phy_read

	// One-cycle receive event, then check the wake exit pulse
	task automatic rx_pulse(input logic uni, input logic [1:0] da,
		input logic wf, input logic mg, input logic exp_exit);
	begin
		@(negedge mclk);
		rx_evt.unicast = uni;
		rx_evt.da_low = da;
		rx_evt.wake_frame = wf;
		rx_evt.magic = mg;
		@(negedge mclk);
		rx_evt = '0;
		chk_bit("wake_exit", exp_exit, wake_exit);
	end
	endtask : rx_pulse

	// Negotiation completion pulse
	task automatic an_pulse;
	begin
		@(negedge mclk);
		an_done = 1'b1;
		@(negedge mclk);
		an_done = 1'b0;
	end
	endtask : an_pulse

	// Verdict and end of run
	task automatic conclude;
	begin
		$display("Compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	end
	endtask : conclude

	// Watchdog against a hang
	initial
	begin
		repeat (5000) @(posedge mclk);
		fail_count++;
		conclude();
	end

	// Main sequence
	initial
	begin
		repeat (4) @(negedge mclk);
		reset = 1'b0;
		reg_read(MWC_IDX_WAKE_CTRL_STATUS, 32'h0);
		reg_read(MWC_IDX_CSUM_OFFLOAD_CTRL, 32'h0);
		reg_read(8'h0b, 32'h0);
		phy_read(MWC_PHY_IDX_BASIC_CTRL, 16'h1000);
		phy_read(MWC_PHY_IDX_BASIC_STAT, 16'h7809);
		phy_read(5'h02, 16'h0);
		// Checksum enables; no live data path and no pad stripping here
		reg_write(MWC_IDX_CSUM_OFFLOAD_CTRL, 32'hffff_ffff);
		chk_word("coe_cfg", 32'h7, {29'h0, coe_cfg});
		reg_read(MWC_IDX_CSUM_OFFLOAD_CTRL, 32'h0001_0003);
		reg_write(MWC_IDX_CSUM_OFFLOAD_CTRL, 32'h0000_0002);
		chk_word("coe_cfg", 32'h2, {29'h0, coe_cfg});
		reg_write(MWC_IDX_CSUM_OFFLOAD_CTRL, 32'h0001_0000);
		chk_word("coe_cfg", 32'h4, {29'h0, coe_cfg});
		// Wake enables, flags and exit pulses
		reg_write(MWC_IDX_WAKE_CTRL_STATUS, 32'hffff_ff9f);
		chk_bit("wake_frame_enable", 1'b1, wake_frame_enable);
		chk_bit("magic_enable", 1'b1, magic_packet_wake_enable);
		reg_read(MWC_IDX_WAKE_CTRL_STATUS, 32'h206);
		rx_pulse(1'b0, 2'b00, 1'b0, 1'b1, 1'b1);
		reg_read(MWC_IDX_WAKE_CTRL_STATUS, 32'h226);
		rx_pulse(1'b0, 2'b00, 1'b1, 1'b0, 1'b1);
		reg_read(MWC_IDX_WAKE_CTRL_STATUS, 32'h266);
		rx_pulse(1'b1, 2'b00, 1'b0, 1'b0, 1'b1);
		rx_pulse(1'b1, 2'b01, 1'b0, 1'b0, 1'b0);
		rx_pulse(1'b1, 2'b10, 1'b0, 1'b0, 1'b0);
		reg_write(MWC_IDX_WAKE_CTRL_STATUS, 32'h0000_0020);
		reg_read(MWC_IDX_WAKE_CTRL_STATUS, 32'h040);
		rx_pulse(1'b1, 2'b00, 1'b0, 1'b1, 1'b0);
		reg_read(MWC_IDX_WAKE_CTRL_STATUS, 32'h040);
		// PHY forced modes
		phy_write(MWC_PHY_IDX_BASIC_CTRL, 16'h6180);
		chk_word("phy_ctl", 32'h33, {26'h0, phy_ctl});
		phy_read(MWC_PHY_IDX_BASIC_CTRL, 16'h6180);
		phy_write(MWC_PHY_IDX_BASIC_CTRL, 16'h0800);
		chk_word("phy_ctl", 32'h04, {26'h0, phy_ctl});
		// Negotiation on, completion and restart
		phy_write(MWC_PHY_IDX_BASIC_CTRL, 16'h1000);
		an_pulse();
		phy_read(MWC_PHY_IDX_BASIC_STAT, 16'h7829);
		chk_word("phy_ctl", 32'h1a, {26'h0, phy_ctl});
		phy_write(MWC_PHY_IDX_BASIC_CTRL, 16'h1200);
		chk_bit("phy_an_restart", 1'b1, phy_an_restart);
		@(negedge mclk);
		chk_bit("phy_an_restart", 1'b0, phy_an_restart);
		phy_read(MWC_PHY_IDX_BASIC_CTRL, 16'h1000);
		phy_read(MWC_PHY_IDX_BASIC_STAT, 16'h7809);
		// PHY soft reset restores defaults and self-clears
		an_pulse();
		phy_write(MWC_PHY_IDX_BASIC_CTRL, 16'hc080);
		phy_read(MWC_PHY_IDX_BASIC_CTRL, 16'h9000);
		repeat (SRST) @(negedge mclk);
		chk_bit("phy_soft_reset", 1'b0, phy_soft_reset);
		phy_read(MWC_PHY_IDX_BASIC_CTRL, 16'h1000);
		phy_read(MWC_PHY_IDX_BASIC_STAT, 16'h7809);
		// Soft reset window length
		phy_write(MWC_PHY_IDX_BASIC_CTRL, 16'h8000);
		n = 0;
		while (phy_soft_reset === 1'b1 && n < 100)
		begin
			n++;
			@(negedge mclk);
		end
		chk_word("soft_reset_cycles", SRST, n);
		// Second hardware reset in mid-run
		reset = 1'b1;
		@(negedge mclk);
		reset = 1'b0;
		reg_read(MWC_IDX_WAKE_CTRL_STATUS, 32'h0);
		reg_read(MWC_IDX_CSUM_OFFLOAD_CTRL, 32'h0);
		conclude();
	end
endmodule : mwc_regs_test
`default_nettype wire

// ---- verilog/mwc_pkg.sv ----
// Package: offsets, field positions, defaults and carriers for the block
package mwc_pkg;

	// MAC register indexes
	localparam logic [7:0] MWC_IDX_WAKE_CTRL_STATUS = 8'h0c;
	localparam logic [7:0] MWC_IDX_CSUM_OFFLOAD_CTRL = 8'h0d;
	localparam logic [31:0] MWC_WAKE_RESET = 32'h0000_0000;
	localparam logic [31:0] MWC_COE_RESET = 32'h0000_0000;

	// Wake control/status field positions
	localparam int MWC_WAKE_UNI_BIT = 9;
	localparam int MWC_WAKE_FRM_FLAG_BIT = 6;
	localparam int MWC_WAKE_MAG_FLAG_BIT = 5;
	localparam int MWC_WAKE_FRM_EN_BIT = 2;
	localparam int MWC_WAKE_MAG_EN_BIT = 1;

	// Checksum offload field positions
	localparam int MWC_COE_TX_EN_BIT = 16;
	localparam int MWC_COE_RX_MODE_BIT = 1;
	localparam int MWC_COE_RX_EN_BIT = 0;

	// PHY register indexes
	localparam logic [4:0] MWC_PHY_IDX_BASIC_CTRL = 5'h00;
	localparam logic [4:0] MWC_PHY_IDX_BASIC_STAT = 5'h01;

	// PHY basic control field positions
	localparam int MWC_PCTL_RESET_BIT = 15;
	localparam int MWC_PCTL_LOOP_BIT = 14;
	localparam int MWC_PCTL_SPEED_BIT = 13;
	localparam int MWC_PCTL_AN_EN_BIT = 12;
	localparam int MWC_PCTL_PDOWN_BIT = 11;
	localparam int MWC_PCTL_AN_RESTART_BIT = 9;
	localparam int MWC_PCTL_DUPLEX_BIT = 8;
	localparam int MWC_PCTL_COL_TEST_BIT = 7;
	localparam logic [15:0] MWC_PCTL_RESET = 16'h1000;
	localparam logic [15:0] MWC_PCTL_WMASK = 16'h7980;

	// PHY basic status: fixed ability bits, completion flag position
	localparam logic [15:0] MWC_PSTAT_FIXED = 16'h7809;
	localparam int MWC_PSTAT_AN_DONE_BIT = 5;

	// Timing
	localparam int MWC_CLK_NS = 40;
	localparam int MWC_PHY_SRST_NS = 1000;
	localparam int MWC_PHY_SRST_CYC =
		(MWC_PHY_SRST_NS + MWC_CLK_NS - 1) / MWC_CLK_NS;

	// Receive-side detector events
	typedef struct packed {
		logic unicast;
		logic [1:0] da_low;
		logic wake_frame;
		logic magic;
	} mwc_rx_evt_t;

	// Checksum engine controls
	typedef struct packed {
		logic tx_engine_enable;
		logic rx_start_mode;
		logic rx_engine_enable;
	} mwc_coe_cfg_t;

	// PHY controls as applied
	typedef struct packed {
		logic loopback;
		logic speed_100;
		logic an_enable;
		logic power_down;
		logic full_duplex;
		logic col_test;
	} mwc_phy_ctl_t;

endpackage : mwc_pkg

// ---- verilog/mwc_regs.sv ----
// Wake, checksum offload and PHY basic control register logic
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// (RULE1) Unicast wake enable: unicast frame with address low bits zero ends power save.
// (RULE2) Valid wake-up frame sets the wake-frame-received flag.
// (RULE3) Valid magic packet sets the magic-packet-received flag.
// (RULE4) Wake-frame enable turns on wake-up frame detection.
// (RULE5) Magic packet enable turns on magic packet detection.
// (RULE6) Bit 16 enables the transmit checksum engine, else bypassed.
// (RULE7) Software changes transmit engine enable only with transmit path off.
// (RULE8) Transmit engine enable needs store-and-forward enabled by software.
// (RULE9) Receive mode bit: 0 starts after 14 bytes, 1 at layer 3.
// (RULE10) Software changes receive start mode only with receive path off.
// (RULE11) Bit 0 enables the receive checksum engine, else bypassed.
// (RULE12) Software toggles receive engine enable only with receive path off.
// (RULE13) Software never enables receive engine together with pad stripping.
// (RULE14) PHY registers are reached only by index, not memory mapped.
// (RULE15) PHY index map: 0 control, 1 status, others as listed.
// (RULE16) Fields kept across soft reset survive only the PHY soft reset.
// (RULE17) Control bit 15 starts a PHY soft reset and clears itself.
// (RULE18) Control bit 14 selects loopback, resets to 0.
// (RULE19) Bit 13 forces 100 Mbps, ignored under auto-negotiation.
// (RULE20) Bit 12 enables auto-negotiation, default 1, overrides speed and duplex.
// (RULE21) Bit 8 forces full duplex, ignored under auto-negotiation.
// (RULE22) Bit 11 powers down; after clearing, negotiation may set status bit 5.
// (RULE23) Bit 9 restarts negotiation and self clears; bit 7 collision test.
// (RULE24) Status bit 5 reads 1 once negotiation has completed.
// (RULE25) Received flags stay set until cleared; reserved bits read zero.
module mwc_regs
	import mwc_pkg::*;
#(
	parameter logic [15:0] KEPT_ACROSS_SOFT_RESET_MASK = 16'h0000,
	parameter int SRST_CYC = MWC_PHY_SRST_CYC
)
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_index,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic phy_wr,
	input wire logic phy_rd,
	input wire logic [4:0] phy_index,
	input wire logic [15:0] phy_wdata,
	output logic [15:0] phy_rdata,
	output logic phy_rvalid,
	input wire mwc_rx_evt_t rx_evt,
	input wire logic an_done,
	input wire logic an_speed_100,
	input wire logic an_full_duplex,
	output logic wake_frame_enable,
	output logic magic_packet_wake_enable,
	output logic wake_exit,
	output mwc_coe_cfg_t coe_cfg,
	output mwc_phy_ctl_t phy_ctl,
	output logic phy_soft_reset,
	output logic phy_an_restart
);

	logic uni_wake_en_ff, wf_flag_ff, mg_flag_ff, wf_en_ff, mg_en_ff;
	logic nxt_uni_wake_en, nxt_wf_flag, nxt_mg_flag, nxt_wf_en, nxt_mg_en;
	mwc_coe_cfg_t coe_ff, nxt_coe;
	logic wake_exit_ff, nxt_wake_exit;
	logic wr_wake, wr_coe, wf_set, mg_set, uni_hit;
	logic [15:0] pctl_ff, nxt_pctl;
	logic an_cmp_ff, nxt_an_cmp;
	logic restart_ff, nxt_restart;
	mwc_phy_ctl_t pout_ff, nxt_pout;
	logic wr_pctl, srst_req, srst_busy;
	logic [31:0] rdata_ff, nxt_rdata;
	logic rvalid_ff;
	logic [15:0] prdata_ff, nxt_prdata;
	logic prvalid_ff;

	// Decode and detector qualification
	assign wr_wake = reg_wr && reg_index == MWC_IDX_WAKE_CTRL_STATUS;
	assign wr_coe = reg_wr && reg_index == MWC_IDX_CSUM_OFFLOAD_CTRL;
	assign wf_set = rx_evt.wake_frame && wf_en_ff; // [RULE2] [RULE4]
	assign mg_set = rx_evt.magic && mg_en_ff; // [RULE3] [RULE5]
	assign uni_hit = uni_wake_en_ff && rx_evt.unicast
		&& rx_evt.da_low == 2'b00; // [RULE1]

	// MAC wake and checksum register next state
	always_comb
	begin
		nxt_uni_wake_en = uni_wake_en_ff;
		nxt_wf_en = wf_en_ff;
		nxt_mg_en = mg_en_ff;
		nxt_coe = coe_ff;
		if (wr_wake)
		begin
			nxt_uni_wake_en = reg_wdata[MWC_WAKE_UNI_BIT];
			nxt_wf_en = reg_wdata[MWC_WAKE_FRM_EN_BIT];
			nxt_mg_en = reg_wdata[MWC_WAKE_MAG_EN_BIT];
		end
		if (wr_coe)
		begin
			nxt_coe.tx_engine_enable = reg_wdata[MWC_COE_TX_EN_BIT]; // [RULE6]
			nxt_coe.rx_start_mode = reg_wdata[MWC_COE_RX_MODE_BIT]; // [RULE9]
			nxt_coe.rx_engine_enable = reg_wdata[MWC_COE_RX_EN_BIT]; // [RULE11]
		end
		// Sticky flags, write 1 clears, a new event wins
		nxt_wf_flag = wf_set
			|| (wf_flag_ff && !(wr_wake && reg_wdata[MWC_WAKE_FRM_FLAG_BIT]));
		nxt_mg_flag = mg_set
			|| (mg_flag_ff && !(wr_wake && reg_wdata[MWC_WAKE_MAG_FLAG_BIT]));
		nxt_wake_exit = uni_hit || wf_set || mg_set; // [RULE1] [RULE25]
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			uni_wake_en_ff <= MWC_WAKE_RESET[MWC_WAKE_UNI_BIT];
			wf_en_ff <= MWC_WAKE_RESET[MWC_WAKE_FRM_EN_BIT];
			mg_en_ff <= MWC_WAKE_RESET[MWC_WAKE_MAG_EN_BIT];
			wf_flag_ff <= MWC_WAKE_RESET[MWC_WAKE_FRM_FLAG_BIT];
			mg_flag_ff <= MWC_WAKE_RESET[MWC_WAKE_MAG_FLAG_BIT];
			coe_ff <= '0;
			wake_exit_ff <= 1'b0;
		end
		else
		begin
			uni_wake_en_ff <= nxt_uni_wake_en;
			wf_en_ff <= nxt_wf_en;
			mg_en_ff <= nxt_mg_en;
			wf_flag_ff <= nxt_wf_flag;
			mg_flag_ff <= nxt_mg_flag;
			coe_ff <= nxt_coe;
			wake_exit_ff <= nxt_wake_exit;
		end
	end

	// PHY soft reset window
	assign wr_pctl = phy_wr && phy_index == MWC_PHY_IDX_BASIC_CTRL; // [RULE14]
	assign srst_req = wr_pctl && phy_wdata[MWC_PCTL_RESET_BIT]; // [RULE17]

	mwc_span_timer #(.COUNT(SRST_CYC), .W(8)) u_srst_timer (
		.mclk(mclk),
		.reset(reset),
		.start(srst_req),
		.busy(srst_busy)
	);

	// PHY basic control, completion flag and applied controls
	always_comb
	begin
		nxt_pctl = pctl_ff;
		nxt_restart = 1'b0;
		if (srst_req)
			nxt_pctl = (pctl_ff & KEPT_ACROSS_SOFT_RESET_MASK)
				| (MWC_PCTL_RESET & ~KEPT_ACROSS_SOFT_RESET_MASK); // [RULE16] [RULE18]
		else if (wr_pctl)
		begin
			nxt_pctl = phy_wdata & MWC_PCTL_WMASK;
			nxt_restart = phy_wdata[MWC_PCTL_AN_RESTART_BIT]; // [RULE23]
		end
		// Forced bits pick up the negotiated result as their default
		if (an_done && pctl_ff[MWC_PCTL_AN_EN_BIT] && !srst_req && !wr_pctl)
		begin
			nxt_pctl[MWC_PCTL_SPEED_BIT] = an_speed_100; // [RULE19]
			nxt_pctl[MWC_PCTL_DUPLEX_BIT] = an_full_duplex; // [RULE21]
		end
		// Completion flag: set wins over any clear
		nxt_an_cmp = an_cmp_ff;
		if (srst_req || nxt_restart || !nxt_pctl[MWC_PCTL_AN_EN_BIT]
			|| nxt_pctl[MWC_PCTL_PDOWN_BIT])
			nxt_an_cmp = 1'b0;
		if (an_done && pctl_ff[MWC_PCTL_AN_EN_BIT]
			&& !pctl_ff[MWC_PCTL_PDOWN_BIT] && !srst_busy)
			nxt_an_cmp = 1'b1; // [RULE22] [RULE24]
		nxt_pout.loopback = nxt_pctl[MWC_PCTL_LOOP_BIT]; // [RULE18]
		nxt_pout.an_enable = nxt_pctl[MWC_PCTL_AN_EN_BIT]; // [RULE20]
		nxt_pout.speed_100 = nxt_pctl[MWC_PCTL_AN_EN_BIT] ? an_speed_100
			: nxt_pctl[MWC_PCTL_SPEED_BIT]; // [RULE19] [RULE20]
		nxt_pout.full_duplex = nxt_pctl[MWC_PCTL_AN_EN_BIT] ? an_full_duplex
			: nxt_pctl[MWC_PCTL_DUPLEX_BIT]; // [RULE21]
		nxt_pout.power_down = nxt_pctl[MWC_PCTL_PDOWN_BIT]; // [RULE22]
		nxt_pout.col_test = nxt_pctl[MWC_PCTL_COL_TEST_BIT]; // [RULE23]
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			pctl_ff <= MWC_PCTL_RESET;
			an_cmp_ff <= 1'b0;
			restart_ff <= 1'b0;
			pout_ff <= '0;
		end
		else
		begin
			pctl_ff <= nxt_pctl;
			an_cmp_ff <= nxt_an_cmp;
			restart_ff <= nxt_restart;
			pout_ff <= nxt_pout;
		end
	end

	// Read data for both ports, unmapped indexes read zero
	always_comb
	begin
		nxt_rdata = '0;
		if (reg_index == MWC_IDX_WAKE_CTRL_STATUS)
		begin
			nxt_rdata[MWC_WAKE_UNI_BIT] = uni_wake_en_ff;
			nxt_rdata[MWC_WAKE_FRM_FLAG_BIT] = wf_flag_ff;
			nxt_rdata[MWC_WAKE_MAG_FLAG_BIT] = mg_flag_ff;
			nxt_rdata[MWC_WAKE_FRM_EN_BIT] = wf_en_ff;
			nxt_rdata[MWC_WAKE_MAG_EN_BIT] = mg_en_ff; // [RULE25]
		end
		else if (reg_index == MWC_IDX_CSUM_OFFLOAD_CTRL)
		begin
			nxt_rdata[MWC_COE_TX_EN_BIT] = coe_ff.tx_engine_enable;
			nxt_rdata[MWC_COE_RX_MODE_BIT] = coe_ff.rx_start_mode;
			nxt_rdata[MWC_COE_RX_EN_BIT] = coe_ff.rx_engine_enable;
		end
		nxt_prdata = '0;
		case (phy_index) // [RULE15]
			MWC_PHY_IDX_BASIC_CTRL:
			begin
				nxt_prdata = pctl_ff;
				nxt_prdata[MWC_PCTL_RESET_BIT] = srst_busy; // [RULE17]
			end
			MWC_PHY_IDX_BASIC_STAT:
			begin
				nxt_prdata = MWC_PSTAT_FIXED;
				nxt_prdata[MWC_PSTAT_AN_DONE_BIT] = an_cmp_ff; // [RULE24]
			end
			default: nxt_prdata = '0;
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			rdata_ff <= '0;
			rvalid_ff <= 1'b0;
			prdata_ff <= '0;
			prvalid_ff <= 1'b0;
		end
		else
		begin
			rvalid_ff <= reg_rd;
			prvalid_ff <= phy_rd;
			if (reg_rd)
				rdata_ff <= nxt_rdata;
			if (phy_rd)
				prdata_ff <= nxt_prdata;
		end
	end

	// Outputs
	assign reg_rdata = rdata_ff;
	assign reg_rvalid = rvalid_ff;
	assign phy_rdata = prdata_ff;
	assign phy_rvalid = prvalid_ff;
	assign wake_frame_enable = wf_en_ff;
	assign magic_packet_wake_enable = mg_en_ff;
	assign wake_exit = wake_exit_ff;
	assign coe_cfg = coe_ff;
	assign phy_ctl = pout_ff;
	assign phy_soft_reset = srst_busy;
	assign phy_an_restart = restart_ff;

	// Checks, all on the rising clock edge outside reset
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	localparam int SRST_LAST = SRST_CYC - 1;

	sequence s_srst_req;
		phy_wr && phy_index == MWC_PHY_IDX_BASIC_CTRL
			&& phy_wdata[MWC_PCTL_RESET_BIT];
	endsequence

	sequence s_restart_req;
		phy_wr && phy_index == MWC_PHY_IDX_BASIC_CTRL
			&& !phy_wdata[MWC_PCTL_RESET_BIT]
			&& phy_wdata[MWC_PCTL_AN_RESTART_BIT];
	endsequence

	uni_wake_exit_a: assert property ( // [RULE1]
		uni_wake_en_ff && rx_evt.unicast && rx_evt.da_low == 2'b00
		|=> wake_exit)
		else $error("unicast wake missed");
	frame_flag_set_a: assert property ( // [RULE2]
		rx_evt.wake_frame && wake_frame_enable |=> wf_flag_ff && wake_exit)
		else $error("wake frame flag not set");
	magic_flag_set_a: assert property ( // [RULE3]
		rx_evt.magic && magic_packet_wake_enable |=> mg_flag_ff)
		else $error("magic flag not set");
	frame_gate_a: assert property ( // [RULE4]
		!wake_frame_enable && !wf_flag_ff && !wr_wake |=> !wf_flag_ff)
		else $error("wake frame flag set while disabled");
	magic_enable_a: assert property ( // [RULE5]
		wr_wake |=> magic_packet_wake_enable
			== $past(reg_wdata[MWC_WAKE_MAG_EN_BIT]))
		else $error("magic enable not stored");
	tx_engine_en_a: assert property ( // [RULE6]
		wr_coe |=> coe_cfg.tx_engine_enable
			== $past(reg_wdata[MWC_COE_TX_EN_BIT]))
		else $error("tx engine enable wrong");
	rx_start_mode_a: assert property ( // [RULE9]
		wr_coe |=> coe_cfg.rx_start_mode
			== $past(reg_wdata[MWC_COE_RX_MODE_BIT]))
		else $error("rx start mode wrong");
	rx_engine_en_a: assert property ( // [RULE11]
		!wr_coe |=> $stable(coe_cfg.rx_engine_enable))
		else $error("rx engine enable changed without write");
	rx_engine_store_a: assert property ( // [RULE11]
		wr_coe |=> coe_cfg.rx_engine_enable
			== $past(reg_wdata[MWC_COE_RX_EN_BIT]))
		else $error("rx engine enable not stored");
	srst_window_a: assert property ( // [RULE17]
		s_srst_req |=> phy_soft_reset ##SRST_LAST phy_soft_reset
			##1 !phy_soft_reset)
		else $error("soft reset window wrong");
	srst_loop_clr_a: assert property ( // [RULE18]
		s_srst_req |=> !phy_ctl.loopback && phy_ctl.an_enable)
		else $error("soft reset did not restore defaults");
	an_override_a: assert property ( // [RULE20]
		phy_ctl.an_enable |-> phy_ctl.speed_100 == $past(an_speed_100))
		else $error("forced speed used under negotiation");
	restart_pulse_a: assert property ( // [RULE23]
		s_restart_req ##1 !phy_wr |-> phy_an_restart ##1 !phy_an_restart)
		else $error("restart not a single pulse");
	an_status_read_a: assert property ( // [RULE24]
		phy_rd && phy_index == MWC_PHY_IDX_BASIC_STAT
		|=> phy_rdata[MWC_PSTAT_AN_DONE_BIT] == $past(an_cmp_ff))
		else $error("status bit 5 wrong");
	flag_sticky_a: assert property ( // [RULE25]
		mg_flag_ff && !wr_wake |=> mg_flag_ff)
		else $error("magic flag lost");

endmodule : mwc_regs
`default_nettype wire

// ---- verilog/mwc_span_timer.sv ----
// Fixed-length busy window started by a one-cycle pulse
`timescale 1ns/10ps
`default_nettype none
module mwc_span_timer
#(
	parameter int COUNT = 25,
	parameter int W = 8
)
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic start,
	output logic busy
);

	logic [W-1:0] cnt_ff;
	logic [W-1:0] nxt_cnt;
	logic busy_ff;
	logic nxt_busy;

	// Load on start, count down, drop busy at zero
	always_comb
	begin
		nxt_cnt = cnt_ff;
		nxt_busy = busy_ff;
		if (start)
		begin
			nxt_cnt = W'(COUNT - 1);
			nxt_busy = 1'b1;
		end
		else if (busy_ff)
		begin
			if (cnt_ff == '0)
				nxt_busy = 1'b0;
			else
				nxt_cnt = cnt_ff - 1'b1;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			cnt_ff <= '0;
			busy_ff <= 1'b0;
		end
		else
		begin
			cnt_ff <= nxt_cnt;
			busy_ff <= nxt_busy;
		end
	end

	assign busy = busy_ff;

endmodule : mwc_span_timer
`default_nettype wire
